// ==== hw/pbr_regs.sv ====
/*
  Power, bias and headphone offset readback register bank, reached over
  the two-wire control port: device address byte, register address byte,
  then 16-bit words high byte first, with auto-increment.
  Assumes scl and sda inputs are already synchronous to mclk_in and that
  mclk_in is at least ten times the bit rate of the control port.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Each headphone channel's present offset correction value is readable.
// - Right readback sits in bits 7:0 at 0x59, signed, resets to zero.
// - Left readback sits in bits 7:0 at 0x5A, same format, resets zero.
// - Bit 0 at 0x39 enables the mid-rail reference bias; resets disabled.
// - Enabled mid-rail reference ramps gradually, never stepping.
// - Divider select 0x01 bits 2:1: off, normal, standby, fast start-up.
// - Divider select resets to fast start-up; software lowers it later.
// - Bit 0 at 0x01 enables normal bias; works only with reference enabled.
// - At 0x01, bit 12 speaker output, bit 9 left stage; reset off.
// - Bit 8 at 0x01 enables the right headphone input stage; reset off.
// - At 0x02 bit 14 sensor enable, bit 13 overtemp disable; both act.
// - At 0x02 bits 7 to 4 enable four input amplifiers; reset off.
// - Bit 15 at 0x02 is read-only overtemperature status.
module pbr_regs #(
  // Value is arbitrary; set per board
  parameter logic [6:0] DEVICE_ADDRESS = 7'h1A
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] offset_value_right_readback_in,
  input wire logic [7:0] offset_value_left_readback_in,
  input wire logic overtemp_sense_in,
  output logic speaker_output_enable_out,
  output logic hp_left_stage_enable_out,
  output logic hp_right_stage_enable_out,
  output logic normal_bias_enable_out,
  output pbr_pkg::pbr_divider_t midrail_divider_select_out,
  output logic midrail_ref_enable_out,
  output logic [7:0] midrail_reference_level_out,
  output logic midrail_reference_settled_out,
  output logic thermal_sensor_enable_out,
  output logic overtemp_status_out,
  output logic overtemp_shutdown_out,
  output logic [3:0] input_amp_enable_out
);
  import pbr_pkg::*;

  typedef struct packed {
    pbr_tw_state_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] reg_addr;
    logic [7:0] wr_hi;
    logic rd_mode;
    logic master_ack;
    logic drive_low;
    logic speaker_output_enable;
    logic hp_left_stage_enable;
    logic hp_right_stage_enable;
    pbr_divider_t midrail_divider_select;
    logic normal_bias_enable;
    logic thermal_sensor_enable;
    logic overtemp_output_disable;
    logic overtemp_status;
    logic [3:0] input_amp_enable;
    logic midrail_ref_enable;
    logic [7:0] offset_right;
    logic [7:0] offset_left;
  } pbr_regs_state_t;

  pbr_regs_state_t cur;
  pbr_regs_state_t next_cur;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [15:0] word;

  // ----------------------------------------------------------------
  // Register read and write
  // ----------------------------------------------------------------
  function automatic logic [15:0] read_word(input pbr_regs_state_t s, input logic [7:0] addr);
    logic [15:0] w;
    w = 16'h0000; // Unlisted bits and addresses read zero
    unique case (addr)
      PBR_POWER_CONTROL_ONE: begin
        w[PBR_SPEAKER_OUTPUT_ENABLE_BIT] = s.speaker_output_enable;
        w[PBR_HP_LEFT_STAGE_ENABLE_BIT] = s.hp_left_stage_enable;
        w[PBR_HP_RIGHT_STAGE_ENABLE_BIT] = s.hp_right_stage_enable;
        w[PBR_DIVIDER_SELECT_LSB +: 2] = s.midrail_divider_select;
        w[PBR_NORMAL_BIAS_ENABLE_BIT] = s.normal_bias_enable;
      end
      PBR_POWER_CONTROL_TWO: begin
        w[PBR_OVERTEMP_STATUS_BIT] = s.overtemp_status;
        w[PBR_THERMAL_SENSOR_ENABLE_BIT] = s.thermal_sensor_enable;
        w[PBR_OVERTEMP_OUTPUT_DISABLE_BIT] = s.overtemp_output_disable;
        w[PBR_INPUT_AMP_ENABLE_LSB +: 4] = s.input_amp_enable;
      end
      PBR_ANTIPOP_REFERENCE_CONTROL: w[PBR_MIDRAIL_REF_ENABLE_BIT] = s.midrail_ref_enable;
      PBR_OFFSET_READBACK_RIGHT: w[7:0] = s.offset_right;
      PBR_OFFSET_READBACK_LEFT: w[7:0] = s.offset_left;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  function automatic pbr_regs_state_t write_word(input pbr_regs_state_t s, input logic [7:0] addr,
                                                 input logic [15:0] w);
    pbr_regs_state_t r;
    r = s;
    unique case (addr)
      PBR_POWER_CONTROL_ONE: begin
        r.speaker_output_enable = w[PBR_SPEAKER_OUTPUT_ENABLE_BIT];
        r.hp_left_stage_enable = w[PBR_HP_LEFT_STAGE_ENABLE_BIT];
        r.hp_right_stage_enable = w[PBR_HP_RIGHT_STAGE_ENABLE_BIT];
        r.midrail_divider_select = pbr_divider_t'(w[PBR_DIVIDER_SELECT_LSB +: 2]);
        r.normal_bias_enable = w[PBR_NORMAL_BIAS_ENABLE_BIT];
      end
      PBR_POWER_CONTROL_TWO: begin
        // Status bit is not writable
        r.thermal_sensor_enable = w[PBR_THERMAL_SENSOR_ENABLE_BIT];
        r.overtemp_output_disable = w[PBR_OVERTEMP_OUTPUT_DISABLE_BIT];
        r.input_amp_enable = w[PBR_INPUT_AMP_ENABLE_LSB +: 4];
      end
      PBR_ANTIPOP_REFERENCE_CONTROL: r.midrail_ref_enable = w[PBR_MIDRAIL_REF_ENABLE_BIT];
      default: r = s; // Readback and unmapped addresses ignore writes
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Two-wire slave and register state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.scl_q = scl_in;
    next_cur.sda_q = sda_in;
    scl_rise = scl_in && !cur.scl_q;
    scl_fall = !scl_in && cur.scl_q;
    start_seen = scl_in && cur.scl_q && cur.sda_q && !sda_in;
    stop_seen = scl_in && cur.scl_q && !cur.sda_q && sda_in;
    word = 16'h0000;

    // Readback tracks the live correction values
    next_cur.offset_right = offset_value_right_readback_in;
    next_cur.offset_left = offset_value_left_readback_in;
    // Status only meaningful with the sensor on
    next_cur.overtemp_status = cur.thermal_sensor_enable && overtemp_sense_in;

    if (start_seen) begin
      next_cur.st = PBR_TW_DEVADDR;
      next_cur.bit_cnt = 4'h0;
      next_cur.drive_low = 1'b0;
    end else if (stop_seen) begin
      next_cur.st = PBR_TW_IDLE;
      next_cur.drive_low = 1'b0;
    end else begin
      unique case (cur.st)
        PBR_TW_IDLE: next_cur.drive_low = 1'b0;
        PBR_TW_DEVADDR, PBR_TW_REGADDR, PBR_TW_WR_HI, PBR_TW_WR_LO: begin
          if (scl_rise) begin
            next_cur.shift = {cur.shift[6:0], sda_in};
            next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          end else if (scl_fall && cur.bit_cnt == PBR_BITS_PER_BYTE) begin
            next_cur.drive_low = 1'b1;
            unique case (cur.st)
              PBR_TW_DEVADDR: begin
                if (cur.shift[7:1] == DEVICE_ADDRESS) begin
                  next_cur.rd_mode = cur.shift[0];
                  next_cur.st = PBR_TW_ACK_DEV;
                end else begin
                  // Other devices' traffic is left alone
                  next_cur.drive_low = 1'b0;
                  next_cur.st = PBR_TW_IDLE;
                end
              end
              PBR_TW_REGADDR: begin
                next_cur.reg_addr = cur.shift;
                next_cur.st = PBR_TW_ACK_REG;
              end
              PBR_TW_WR_HI: begin
                next_cur.wr_hi = cur.shift;
                next_cur.st = PBR_TW_ACK_HI;
              end
              default: begin
                next_cur = write_word(next_cur, cur.reg_addr, {cur.wr_hi, cur.shift});
                next_cur.st = PBR_TW_ACK_LO;
              end
            endcase
          end
        end
        PBR_TW_ACK_DEV: begin
          if (scl_fall) begin
            next_cur.bit_cnt = 4'h0;
            if (cur.rd_mode) begin
              word = read_word(cur, cur.reg_addr);
              next_cur.shift = word[15:8];
              next_cur.drive_low = !word[15];
              next_cur.st = PBR_TW_RD_HI;
            end else begin
              next_cur.drive_low = 1'b0;
              next_cur.st = PBR_TW_REGADDR;
            end
          end
        end
        PBR_TW_ACK_REG, PBR_TW_ACK_HI, PBR_TW_ACK_LO: begin
          if (scl_fall) begin
            next_cur.bit_cnt = 4'h0;
            next_cur.drive_low = 1'b0;
            next_cur.st = (cur.st == PBR_TW_ACK_HI) ? PBR_TW_WR_LO : PBR_TW_WR_HI;
            if (cur.st == PBR_TW_ACK_LO) begin
              next_cur.reg_addr = cur.reg_addr + 8'h01;
            end
          end
        end
        PBR_TW_RD_HI, PBR_TW_RD_LO: begin
          if (scl_rise) begin
            next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (cur.bit_cnt == PBR_BITS_PER_BYTE) begin
              next_cur.drive_low = 1'b0;
              next_cur.st = (cur.st == PBR_TW_RD_HI) ? PBR_TW_RD_ACK_HI : PBR_TW_RD_ACK_LO;
            end else begin
              next_cur.shift = {cur.shift[6:0], 1'b0};
              next_cur.drive_low = !cur.shift[6];
            end
          end
        end
        PBR_TW_RD_ACK_HI, PBR_TW_RD_ACK_LO: begin
          if (scl_rise) begin
            next_cur.master_ack = !sda_in;
          end else if (scl_fall) begin
            next_cur.bit_cnt = 4'h0;
            if (!cur.master_ack) begin
              // Master ends the read with a not-acknowledge
              next_cur.drive_low = 1'b0;
              next_cur.st = PBR_TW_IDLE;
            end else if (cur.st == PBR_TW_RD_ACK_HI) begin
              word = read_word(cur, cur.reg_addr);
              next_cur.shift = word[7:0];
              next_cur.drive_low = !word[7];
              next_cur.st = PBR_TW_RD_LO;
            end else begin
              word = read_word(cur, cur.reg_addr + 8'h01);
              next_cur.reg_addr = cur.reg_addr + 8'h01;
              next_cur.shift = word[15:8];
              next_cur.drive_low = !word[15];
              next_cur.st = PBR_TW_RD_HI;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cur <= '0;
      cur.st <= PBR_TW_IDLE;
      cur.scl_q <= 1'b1;
      cur.sda_q <= 1'b1;
      cur.midrail_divider_select <= PBR_DIVIDER_SELECT_RESET;
      cur.thermal_sensor_enable <= PBR_THERMAL_SENSOR_ENABLE_RESET;
      cur.overtemp_output_disable <= PBR_OVERTEMP_OUTPUT_DISABLE_RESET;
      cur.offset_right <= PBR_OFFSET_READBACK_RESET;
      cur.offset_left <= PBR_OFFSET_READBACK_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Reference ramp
  // ----------------------------------------------------------------
  pbr_midrail_ramp u_ramp (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .midrail_ref_enable_in(cur.midrail_ref_enable),
    .midrail_divider_select_in(cur.midrail_divider_select),
    .midrail_reference_level_out(midrail_reference_level_out),
    .midrail_reference_settled_out(midrail_reference_settled_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = cur.drive_low;
  // Shutdown needs both the sensor and the disable bit
  assign overtemp_shutdown_out = cur.overtemp_status && cur.overtemp_output_disable;
  assign speaker_output_enable_out = cur.speaker_output_enable && !overtemp_shutdown_out;
  assign hp_left_stage_enable_out = cur.hp_left_stage_enable && !overtemp_shutdown_out;
  assign hp_right_stage_enable_out = cur.hp_right_stage_enable && !overtemp_shutdown_out;
  // Bias current has no source without the reference
  assign normal_bias_enable_out = cur.normal_bias_enable && cur.midrail_ref_enable;
  assign midrail_divider_select_out = cur.midrail_divider_select;
  assign midrail_ref_enable_out = cur.midrail_ref_enable;
  assign thermal_sensor_enable_out = cur.thermal_sensor_enable;
  assign overtemp_status_out = cur.overtemp_status;
  assign input_amp_enable_out = cur.input_amp_enable;

endmodule

// ==== hw/pbr_pkg.sv ====
/*
  Package for the power, bias and offset readback register bank: register
  offsets, field positions, reset values, two-wire states and ramp timing.
  Assumes a single 10 MHz clock from the on-chip oscillator.
*/
package pbr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PBR_POWER_CONTROL_ONE = 8'h01;
  localparam logic [7:0] PBR_POWER_CONTROL_TWO = 8'h02;
  localparam logic [7:0] PBR_ANTIPOP_REFERENCE_CONTROL = 8'h39;
  localparam logic [7:0] PBR_OFFSET_READBACK_RIGHT = 8'h59;
  localparam logic [7:0] PBR_OFFSET_READBACK_LEFT = 8'h5A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PBR_SPEAKER_OUTPUT_ENABLE_BIT = 12;
  localparam int PBR_HP_LEFT_STAGE_ENABLE_BIT = 9;
  localparam int PBR_HP_RIGHT_STAGE_ENABLE_BIT = 8;
  localparam int PBR_DIVIDER_SELECT_LSB = 1;
  localparam int PBR_NORMAL_BIAS_ENABLE_BIT = 0;
  localparam int PBR_OVERTEMP_STATUS_BIT = 15;
  localparam int PBR_THERMAL_SENSOR_ENABLE_BIT = 14;
  localparam int PBR_OVERTEMP_OUTPUT_DISABLE_BIT = 13;
  localparam int PBR_INPUT_AMP_ENABLE_LSB = 4;
  localparam int PBR_MIDRAIL_REF_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // Divider select codes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PBR_DIV_OFF = 2'h0,
    PBR_DIV_NORMAL = 2'h1,
    PBR_DIV_STANDBY = 2'h2,
    PBR_DIV_FAST = 2'h3
  } pbr_divider_t;

  localparam pbr_divider_t PBR_DIVIDER_SELECT_RESET = PBR_DIV_FAST;
  localparam logic PBR_THERMAL_SENSOR_ENABLE_RESET = 1'b0;
  localparam logic PBR_OVERTEMP_OUTPUT_DISABLE_RESET = 1'b1;
  localparam logic [7:0] PBR_OFFSET_READBACK_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Ramp timing: time per reference step, then cycles at 10 MHz
  // ----------------------------------------------------------------
  localparam int PBR_CLK_PERIOD_NS = 100;
  localparam int PBR_STEP_FAST_NS = 1000;
  localparam int PBR_STEP_NORMAL_NS = 10000;
  localparam int PBR_STEP_STANDBY_NS = 50000;
  localparam logic [9:0] PBR_STEP_FAST_CYCLES = 10'(PBR_STEP_FAST_NS / PBR_CLK_PERIOD_NS);
  localparam logic [9:0] PBR_STEP_NORMAL_CYCLES = 10'(PBR_STEP_NORMAL_NS / PBR_CLK_PERIOD_NS);
  localparam logic [9:0] PBR_STEP_STANDBY_CYCLES = 10'(PBR_STEP_STANDBY_NS / PBR_CLK_PERIOD_NS);
  localparam logic [7:0] PBR_LEVEL_FULL = 8'hFF;
  localparam logic [7:0] PBR_LEVEL_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  localparam logic [3:0] PBR_BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    PBR_TW_IDLE,
    PBR_TW_DEVADDR,
    PBR_TW_ACK_DEV,
    PBR_TW_REGADDR,
    PBR_TW_ACK_REG,
    PBR_TW_WR_HI,
    PBR_TW_ACK_HI,
    PBR_TW_WR_LO,
    PBR_TW_ACK_LO,
    PBR_TW_RD_HI,
    PBR_TW_RD_ACK_HI,
    PBR_TW_RD_LO,
    PBR_TW_RD_ACK_LO
  } pbr_tw_state_t;

endpackage

// ==== hw/pbr_midrail_ramp.sv ====
/*
  Soft-start ramp for the mid-rail reference. Moves the reference level
  one step at a time toward its target, at a rate set by the divider.
  Assumes enable and divider select come from registers in the same domain.
*/
`timescale 1ns/1ps

module pbr_midrail_ramp (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic midrail_ref_enable_in,
  input wire pbr_pkg::pbr_divider_t midrail_divider_select_in,
  output logic [7:0] midrail_reference_level_out,
  output logic midrail_reference_settled_out
);
  import pbr_pkg::*;

  typedef struct packed {
    logic [7:0] level;
    logic [9:0] tick;
  } pbr_ramp_state_t;

  pbr_ramp_state_t cur;
  pbr_ramp_state_t next_cur;
  logic [7:0] target;
  logic [9:0] period;

  // ----------------------------------------------------------------
  // Step control
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // Divider off means the reference is discharged even when enabled
    target = (midrail_ref_enable_in && midrail_divider_select_in != PBR_DIV_OFF) ? PBR_LEVEL_FULL : PBR_LEVEL_ZERO;
    unique case (midrail_divider_select_in)
      PBR_DIV_FAST: period = PBR_STEP_FAST_CYCLES;
      PBR_DIV_STANDBY: period = PBR_STEP_STANDBY_CYCLES;
      PBR_DIV_NORMAL: period = PBR_STEP_NORMAL_CYCLES;
      PBR_DIV_OFF: period = PBR_STEP_FAST_CYCLES;
    endcase
    if (cur.level == target) begin
      next_cur.tick = 10'h000;
    end else if (cur.tick + 10'h001 >= period) begin
      // One step per period, never a jump
      next_cur.tick = 10'h000;
      if (cur.level < target) begin
        next_cur.level = cur.level + 8'h01;
      end else begin
        next_cur.level = cur.level - 8'h01;
      end
    end else begin
      next_cur.tick = cur.tick + 10'h001;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign midrail_reference_level_out = cur.level;
  assign midrail_reference_settled_out = (cur.level == target);

endmodule

// ==== tb/pbr_regs_assertions.sv ====
/*
  Port assertions and covers for the power, bias and readback bank.
  Assumes it is bound onto pbr_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module pbr_regs_checker (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic overtemp_sense_in,
  input wire logic speaker_output_enable_out,
  input wire logic hp_left_stage_enable_out,
  input wire logic hp_right_stage_enable_out,
  input wire logic normal_bias_enable_out,
  input wire pbr_pkg::pbr_divider_t midrail_divider_select_out,
  input wire logic midrail_ref_enable_out,
  input wire logic [7:0] midrail_reference_level_out,
  input wire logic midrail_reference_settled_out,
  input wire logic thermal_sensor_enable_out,
  input wire logic overtemp_status_out,
  input wire logic overtemp_shutdown_out,
  input wire logic [3:0] input_amp_enable_out
);
  import pbr_pkg::*;
  logic [7:0] lvl;
  logic ref_en;
  assign lvl = midrail_reference_level_out;
  assign ref_en = midrail_ref_enable_out;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // ------------------------------
  // Assertions
  // ------------------------------
  a_bias_needs_ref: assert property (normal_bias_enable_out |-> ref_en)
    else $error("bias on without reference");
  a_ramp_one_step: assert property (
    $changed(lvl) |-> (8'(lvl - $past(lvl)) == 8'h01) || (8'($past(lvl) - lvl) == 8'h01))
    else $error("reference level stepped");
  a_off_settles_zero: assert property (
    midrail_reference_settled_out && (!ref_en || midrail_divider_select_out == PBR_DIV_OFF) |-> lvl == 8'h00)
    else $error("reference settled above zero while off");
  // Two quiet cycles, so a late-registered enable cannot excuse a rise
  a_off_no_rise: assert property (!ref_en && $past(ref_en) == 1'b0 |=> lvl <= $past(lvl))
    else $error("reference rose while disabled");
  a_hot_gates_out: assert property (
    overtemp_shutdown_out |-> !speaker_output_enable_out && !hp_left_stage_enable_out && !hp_right_stage_enable_out)
    else $error("outputs enabled during shutdown");
  a_shutdown_cause: assert property (overtemp_shutdown_out |-> overtemp_status_out)
    else $error("shutdown without overtemperature");
  a_status_cause: assert property (
    $rose(overtemp_status_out) |-> $past(thermal_sensor_enable_out) && $past(overtemp_sense_in))
    else $error("status rose without cause");
  a_reset_defaults: assert property (
    $rose(reset_n_in) |-> midrail_divider_select_out == PBR_DIV_FAST && input_amp_enable_out == 4'h0
      && !speaker_output_enable_out && !thermal_sensor_enable_out && !ref_en)
    else $error("wrong state after reset");
  c_shutdown: cover property (overtemp_shutdown_out);
  c_full_level: cover property (midrail_reference_settled_out && lvl == 8'hFF);
  c_standby: cover property (midrail_divider_select_out == PBR_DIV_STANDBY);
endmodule

// ==== tb/pbr_regs_tb.sv ====
/*
  Self-checking bench for pbr_regs, driven over the two-wire port.
  Assumes the package, the design and the checker are compiled first.
*/
`timescale 1ns/1ps
module pbr_regs_tb;
  import pbr_pkg::*;
  localparam logic [6:0] DEV = 7'h1A;
  logic mclk = 1'b0, reset_n = 1'b0, scl = 1'b1, sda_m = 1'b1, hot = 1'b0;
  logic [7:0] rb_r = 8'hA5, rb_l = 8'h7F;
  logic sda_out, sda_oe, spk, hpl, hpr, bias, ref_en, settled, ts_en, ot_st, ot_sd;
  logic [7:0] level;
  logic [3:0] amps;
  pbr_divider_t div;
  int errors = 0, n_tests = 0;
  // Open drain: the wire is low when either party pulls
  wire logic sda_w = sda_m & ~sda_oe;
  always #50 mclk = ~mclk;
  pbr_regs #(.DEVICE_ADDRESS(DEV)) u_pbr_regs (.mclk_in(mclk), .reset_n_in(reset_n), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe), .offset_value_right_readback_in(rb_r),
    .offset_value_left_readback_in(rb_l), .overtemp_sense_in(hot), .speaker_output_enable_out(spk),
    .hp_left_stage_enable_out(hpl), .hp_right_stage_enable_out(hpr), .normal_bias_enable_out(bias),
    .midrail_divider_select_out(div), .midrail_ref_enable_out(ref_en), .midrail_reference_level_out(level),
    .midrail_reference_settled_out(settled), .thermal_sensor_enable_out(ts_en),
    .overtemp_status_out(ot_st), .overtemp_shutdown_out(ot_sd), .input_amp_enable_out(amps));
  // ------------------------------
  // Two-wire master and compare
  // ------------------------------
  task automatic nw(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tw_bit(input logic b, output logic r);
    nw(2);
    sda_m = b;
    nw(2);
    scl = 1'b1;
    nw(2);
    r = sda_w;
    nw(2);
    scl = 1'b0;
  endtask
  task automatic tw_start();
    sda_m = 1'b1;
    nw(2);
    scl = 1'b1;
    nw(4);
    sda_m = 1'b0;
    nw(4);
    scl = 1'b0;
  endtask
  task automatic tw_stop();
    nw(2);
    sda_m = 1'b0;
    nw(2);
    scl = 1'b1;
    nw(4);
    sda_m = 1'b1;
    nw(4);
  endtask
  task automatic tw_byte(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) tw_bit(d[i], q[i]);
    tw_bit(last, a);
    ack = ~a;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    logic k;
    tw_start();
    tw_byte({DEV, 1'b0}, 1'b1, q, k);
    tw_byte(a, 1'b1, q, k);
    tw_byte(v[15:8], 1'b1, q, k);
    tw_byte(v[7:0], 1'b1, q, k);
    tw_stop();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    logic k;
    tw_start();
    tw_byte({DEV, 1'b0}, 1'b1, v[7:0], k);
    tw_byte(a, 1'b1, v[7:0], k);
    tw_start();
    tw_byte({DEV, 1'b1}, 1'b1, v[7:0], k);
    tw_byte(8'hFF, 1'b0, v[15:8], k);
    tw_byte(8'hFF, 1'b1, v[7:0], k);
    tw_stop();
    chk(v, e);
  endtask
  task automatic wait_settled();
    int n;
    n = 0;
    while (settled !== 1'b1 && n < 3000) begin
      nw(1);
      n++;
    end
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset_vals();
    rd_chk(PBR_POWER_CONTROL_ONE, 16'h0006);
    rd_chk(PBR_POWER_CONTROL_TWO, 16'h2000);
    rd_chk(PBR_ANTIPOP_REFERENCE_CONTROL, 16'h0000);
    rd_chk(PBR_OFFSET_READBACK_RIGHT, 16'h00A5);
    rd_chk(PBR_OFFSET_READBACK_LEFT, 16'h007F);
    $display("test reset_vals done");
  endtask
  task automatic t_fields();
    reg_write(PBR_POWER_CONTROL_ONE, 16'hFFFF);
    rd_chk(PBR_POWER_CONTROL_ONE, 16'h1307);
    chk({13'h0, spk, hpl, hpr}, 16'h0007);
    chk({15'h0, bias}, 16'h0000);
    reg_write(PBR_ANTIPOP_REFERENCE_CONTROL, 16'hFFFF);
    rd_chk(PBR_ANTIPOP_REFERENCE_CONTROL, 16'h0001);
    chk({15'h0, ref_en}, 16'h0001);
    chk({15'h0, bias}, 16'h0001);
    // Status bit is offered a one but must stay zero; B-side inputs unused
    reg_write(PBR_POWER_CONTROL_TWO, 16'hE0A0);
    rd_chk(PBR_POWER_CONTROL_TWO, 16'h60A0);
    chk({12'h0, amps}, 16'h000A);
    chk({14'h0, ts_en, sda_out}, 16'h0002);
    reg_write(PBR_OFFSET_READBACK_RIGHT, 16'h1234);
    rb_l = 8'h80;
    rd_chk(PBR_OFFSET_READBACK_RIGHT, 16'h00A5);
    rd_chk(PBR_OFFSET_READBACK_LEFT, 16'h0080);
    for (int c = 0; c < 4; c++) begin
      reg_write(PBR_POWER_CONTROL_ONE, 16'(c << 1));
      chk(16'(div), 16'(c));
    end
    $display("test fields done");
  endtask
  task automatic t_burst();
    logic [7:0] q;
    logic [31:0] v;
    logic k;
    tw_start();
    tw_byte({DEV, 1'b0}, 1'b1, q, k);
    tw_byte(PBR_OFFSET_READBACK_RIGHT, 1'b1, q, k);
    tw_start();
    tw_byte({DEV, 1'b1}, 1'b1, q, k);
    // Acknowledged low byte moves on to the next register
    for (int i = 3; i >= 0; i--) tw_byte(8'hFF, i == 0, v[i * 8 +: 8], k);
    tw_stop();
    chk(v[31:16], 16'h00A5);
    chk(v[15:0], 16'h0080);
    $display("test burst done");
  endtask
  task automatic t_ramp();
    reg_write(PBR_ANTIPOP_REFERENCE_CONTROL, 16'h0001);
    wait_settled();
    chk({7'h0, settled, level}, {8'h01, PBR_LEVEL_FULL});
    reg_write(PBR_ANTIPOP_REFERENCE_CONTROL, 16'h0000);
    wait_settled();
    chk({7'h0, settled, level}, 16'h0100);
    $display("test ramp done");
  endtask
  task automatic t_overtemp();
    reg_write(PBR_POWER_CONTROL_ONE, 16'h1306);
    hot = 1'b1;
    nw(4);
    chk({11'h0, ot_st, ot_sd, spk, hpl, hpr}, 16'h0018);
    rd_chk(PBR_POWER_CONTROL_TWO, 16'hE0A0);
    reg_write(PBR_POWER_CONTROL_TWO, 16'h40A0);
    chk({11'h0, ot_st, ot_sd, spk, hpl, hpr}, 16'h0017);
    hot = 1'b0;
    nw(4);
    chk({15'h0, ot_st}, 16'h0000);
    $display("test overtemp done");
  endtask
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    nw(5);
    reset_n = 1'b1;
    nw(4);
    t_reset_vals();
    t_fields();
    t_burst();
    t_ramp();
    t_overtemp();
    print_verdict();
  end
  // Whole run needs about 11000 cycles
  initial begin
    #5_000_000;
    errors++;
    print_verdict();
  end
endmodule
bind pbr_regs pbr_regs_checker u_pbr_regs_checker (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .overtemp_sense_in(overtemp_sense_in), .speaker_output_enable_out(speaker_output_enable_out),
  .hp_left_stage_enable_out(hp_left_stage_enable_out), .hp_right_stage_enable_out(hp_right_stage_enable_out),
  .normal_bias_enable_out(normal_bias_enable_out), .midrail_divider_select_out(midrail_divider_select_out),
  .midrail_ref_enable_out(midrail_ref_enable_out), .midrail_reference_level_out(midrail_reference_level_out),
  .midrail_reference_settled_out(midrail_reference_settled_out),
  .thermal_sensor_enable_out(thermal_sensor_enable_out), .overtemp_status_out(overtemp_status_out),
  .overtemp_shutdown_out(overtemp_shutdown_out), .input_amp_enable_out(input_amp_enable_out));
